// ---- hw/liu_ctrl_regs.sv ----
// serial host port registers for line enables, interrupts, error count and ids
`timescale 1ns/100ps
`default_nettype none
module liu_ctrl_regs import liu_pkg::*; #(
  parameter logic [7:0] PART_ID = 8'hA5, // arbitrary value
  parameter logic [7:0] REV_ID = 8'h01 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic int_n_o,
  input wire logic mon_pulse_i,
  input wire logic bit_tick_i,
  input wire logic receive_signal_loss_i,
  input wire logic receive_lock_loss_i,
  input wire logic fifo_near_limit_i,
  input wire logic ja_enabled_i,
  input wire logic pattern_err_i,
  output logic transmit_turn_on_o,
  output logic receive_turn_on_o,
  output logic driver_monitor_fault_o
);
  // pin synchronisers: {mon, sdi, sclk, cs}
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic sclk_prev_ff;
  liu_state_e state_ff;
  liu_state_e nxt_state;
  logic [4:0] bit_cnt_ff;
  logic [7:0] cmd_ff;
  logic [7:0] dat_ff;
  logic [7:0] rd_shift_ff;
  logic sdo_ff;
  logic sdo_oe_ff;
  logic [1:0] line_ctrl_ff;
  logic [5:0] irq_en_ff;
  logic [5:0] status_ff;
  logic [5:0] nxt_status;
  logic [3:0] cond_prev_ff;
  logic [7:0] hold_ff;
  logic [7:0] dmo_cnt_ff;
  logic dmo_ff;
  logic int_n_ff;
  logic [15:0] err_count;
  logic err_full;

  logic cs_s;
  logic sclk_s;
  logic sdi_s;
  logic mon_s;
  logic sclk_rise;
  logic sclk_fall;
  logic [5:0] addr;
  logic rw_read;
  logic [7:0] rd_data;
  logic wr_line;
  logic wr_en;
  logic rd_status;
  logic rd_cnt_high;
  logic [3:0] cond_now;
  logic [3:0] cond_chg;
  logic [5:0] set_vec;
  logic [5:0] en_eff;
  logic irq_pend;
  logic dmo_expire;

  // synchronised pins and serial clock edges
  assign cs_s = ~sync2_ff[0];
  assign sclk_s = sync2_ff[1];
  assign sdi_s = sync2_ff[2];
  assign mon_s = sync2_ff[3];
  assign sclk_rise = cs_s && sclk_s && !sclk_prev_ff;
  assign sclk_fall = cs_s && !sclk_s && sclk_prev_ff;

  // command byte once shifted: bit 0 read flag, bits 6:1 address lsb first
  assign rw_read = cmd_ff[0];
  assign addr = cmd_ff[6:1];

  // read data selection, unmapped offsets read zero
  assign rd_data = (addr == ADDR_LINE_CTRL) ? {3'h0, line_ctrl_ff[1], 3'h0, line_ctrl_ff[0]} :
                   (addr == ADDR_IRQ_EN) ? {2'h0, irq_en_ff} :
                   (addr == ADDR_IRQ_STATUS) ? {2'h0, status_ff} :
                   (addr == ADDR_CNT_HIGH) ? err_count[15:8] :
                   (addr == ADDR_CNT_LOW) ? err_count[7:0] :
                   (addr == ADDR_HOLD) ? hold_ff :
                   (addr == ADDR_PART) ? PART_ID :
                   (addr == ADDR_REV) ? REV_ID :
                   8'h00;

  // access strobes with their side effects
  assign wr_line = (state_ff == ST_WCOMMIT) && (addr == ADDR_LINE_CTRL);
  assign wr_en = (state_ff == ST_WCOMMIT) && (addr == ADDR_IRQ_EN);
  assign rd_status = (state_ff == ST_RLOAD) && (addr == ADDR_IRQ_STATUS);
  assign rd_cnt_high = (state_ff == ST_RLOAD) && (addr == ADDR_CNT_HIGH);

  // condition change detect and flag update, a set beats a read clear
  assign cond_now = {fifo_near_limit_i, receive_lock_loss_i, receive_signal_loss_i, dmo_ff};
  assign cond_chg = cond_now ^ cond_prev_ff;
  assign set_vec = {err_full, pattern_err_i, cond_chg};
  assign nxt_status = (status_ff & ~{6{rd_status}}) | set_vec;

  // fifo limit enable is ignored while the attenuator is off
  assign en_eff = {irq_en_ff[5:4], irq_en_ff[3] & ja_enabled_i, irq_en_ff[2:0]};
  assign irq_pend = |(status_ff & en_eff);

  // driver monitor expiry after a run of pulseless bit periods
  assign dmo_expire = !mon_s && bit_tick_i && (dmo_cnt_ff == DMO_BIT_PERIODS - 8'h01);

  // serial port sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (cs_s) nxt_state = ST_CMD;
      end
      ST_CMD: begin
        if (!cs_s) nxt_state = ST_IDLE;
        else if (bit_cnt_ff == CMD_BITS) nxt_state = rw_read ? ST_RLOAD : ST_WDATA;
      end
      ST_RLOAD: nxt_state = ST_RDATA;
      ST_RDATA: begin
        if (!cs_s) nxt_state = ST_IDLE;
        else if (sclk_rise && bit_cnt_ff == FRAME_BITS - 5'h01) nxt_state = ST_DONE;
      end
      ST_WDATA: begin
        if (!cs_s) nxt_state = ST_IDLE;
        else if (sclk_rise && bit_cnt_ff == FRAME_BITS - 5'h01) nxt_state = ST_WCOMMIT;
      end
      ST_WCOMMIT: nxt_state = ST_DONE;
      ST_DONE: begin
        if (!cs_s) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // synchronisers and edge history
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff <= 4'h1;
      sync2_ff <= 4'h1;
      sclk_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= {mon_pulse_i, sdi_i, sclk_i, cs_n_i};
      sync2_ff <= sync1_ff;
      sclk_prev_ff <= sclk_s;
    end
  end

  // state, bit counter and shift registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 5'h00;
      cmd_ff <= 8'h00;
      dat_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE) bit_cnt_ff <= 5'h00;
      else if (sclk_rise && bit_cnt_ff != FRAME_BITS) bit_cnt_ff <= bit_cnt_ff + 5'h01;
      if (state_ff == ST_CMD && sclk_rise) cmd_ff <= {sdi_s, cmd_ff[7:1]};
      if (state_ff == ST_WDATA && sclk_rise) dat_ff <= {sdi_s, dat_ff[7:1]};
    end
  end

  // read data out, lsb first, changed on falling serial clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_shift_ff <= 8'h00;
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else begin
      if (state_ff == ST_RLOAD) rd_shift_ff <= rd_data;
      else if (state_ff == ST_RDATA && sclk_fall) rd_shift_ff <= {1'b0, rd_shift_ff[7:1]};
      if (state_ff == ST_RDATA && sclk_fall) sdo_ff <= rd_shift_ff[0];
      sdo_oe_ff <= (nxt_state == ST_RDATA);
    end
  end

  // control and enable registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_ctrl_ff <= LINE_CTRL_RST;
      irq_en_ff <= IRQ_EN_RST;
    end else begin
      if (wr_line) line_ctrl_ff <= {dat_ff[RX_ON_BIT], dat_ff[TX_ON_BIT]};
      if (wr_en) irq_en_ff <= dat_ff[5:0];
    end
  end

  // interrupt flags, condition history, holding byte and interrupt pin
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_ff <= IRQ_STATUS_RST;
      cond_prev_ff <= 4'h0;
      hold_ff <= 8'h00;
      int_n_ff <= 1'b1;
    end else begin
      status_ff <= nxt_status;
      cond_prev_ff <= cond_now;
      if (rd_cnt_high) hold_ff <= err_count[7:0]; // low byte frozen with the high read
      int_n_ff <= ~irq_pend;
    end
  end

  // driver monitor: count bit periods with no pulse seen
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dmo_cnt_ff <= 8'h00;
      dmo_ff <= 1'b0;
    end else begin
      if (mon_s) begin
        dmo_cnt_ff <= 8'h00;
        dmo_ff <= 1'b0;
      end else if (bit_tick_i && !dmo_ff) begin
        dmo_cnt_ff <= dmo_cnt_ff + 8'h01;
        if (dmo_expire) dmo_ff <= 1'b1;
      end
    end
  end

  // pattern error counter
  liu_err_counter u_err_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .err_i(pattern_err_i),
    .count_o(err_count),
    .full_o(err_full)
  );

  // outputs straight from flip-flops; transmit off tri-states the line output pair
  assign transmit_turn_on_o = line_ctrl_ff[0];
  assign receive_turn_on_o = line_ctrl_ff[1];
  assign sdo_o = sdo_ff;
  assign sdo_oe_o = sdo_oe_ff;
  assign int_n_o = int_n_ff;
  assign driver_monitor_fault_o = dmo_ff;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_TX_WRITE: assert property (wr_line |=> transmit_turn_on_o == $past(dat_ff[0]))
    else $error("transmit enable did not follow write");
  AST_RX_WRITE: assert property (wr_line |=> receive_turn_on_o == $past(dat_ff[4]))
    else $error("receive enable did not follow write");
  AST_DRV_IRQ: assert property (status_ff[0] && irq_en_ff[0] |=> !int_n_o)
    else $error("driver fault interrupt missing");
  AST_FL_MASKED: assert property (!ja_enabled_i && (status_ff & irq_en_ff & 6'h37) == 6'h00
    |=> int_n_o)
    else $error("fifo limit interrupt while attenuator off");
  AST_LOS_FLAG: assert property ($changed(receive_signal_loss_i) |=> status_ff[1])
    else $error("signal loss change not flagged");
  AST_PAT_FLAG: assert property (pattern_err_i |=> status_ff[4])
    else $error("pattern error not flagged");
  AST_SAT_FLAG: assert property (err_full |=> status_ff[5] && err_count == ERR_CNT_MAX)
    else $error("saturation not flagged");
  AST_READ_CLR: assert property (rd_status && set_vec == 6'h00 |=> status_ff == 6'h00)
    else $error("status read did not clear flags");
  AST_DMO_SET: assert property (dmo_expire |=> driver_monitor_fault_o ##1 driver_monitor_fault_o
    || $past(mon_s))
    else $error("driver fault not declared");
  AST_INT_RELEASE: assert property (!irq_pend |=> int_n_o)
    else $error("interrupt held without pending flag");
  AST_DRV_FLAG: assert property ($changed(dmo_ff) |=> status_ff[0])
    else $error("driver fault change not flagged");
  AST_LOL_FLAG: assert property ($changed(receive_lock_loss_i) |=> status_ff[2])
    else $error("lock loss change not flagged");
  AST_FL_FLAG: assert property ($changed(fifo_near_limit_i) |=> status_ff[3])
    else $error("fifo limit change not flagged");
  AST_LOS_IRQ: assert property (status_ff[1] && irq_en_ff[1] |=> !int_n_o)
    else $error("signal loss interrupt missing");
  AST_LOL_IRQ: assert property (status_ff[2] && irq_en_ff[2] |=> !int_n_o)
    else $error("lock loss interrupt missing");
  AST_FL_IRQ: assert property (status_ff[3] && irq_en_ff[3] && ja_enabled_i
    |=> !int_n_o)
    else $error("fifo limit interrupt missing");
  AST_PAT_IRQ: assert property (status_ff[4] && irq_en_ff[4] |=> !int_n_o)
    else $error("pattern error interrupt missing");
  AST_SAT_IRQ: assert property (status_ff[5] && irq_en_ff[5] |=> !int_n_o)
    else $error("saturation interrupt missing");
  AST_INT_LOW: assert property (irq_pend |=> !int_n_o)
    else $error("interrupt pin not driven low");
  AST_EN_WRITE: assert property (wr_en |=> irq_en_ff == $past(dat_ff[5:0]))
    else $error("enable register did not follow write");
  AST_OE_READ: assert property (state_ff == ST_RDATA |-> sdo_oe_o)
    else $error("data out not enabled during read");
  AST_HOLD_LATCH: assert property (rd_cnt_high |=> hold_ff == $past(err_count[7:0]))
    else $error("holding byte not frozen on high read");
  AST_DMO_CLEAR: assert property (mon_s |=> !driver_monitor_fault_o)
    else $error("driver fault kept after monitor pulse");

  COV_READ_STATUS: cover property (rd_status ##1 state_ff == ST_RDATA);
  COV_WRITE_CTRL: cover property (wr_line ##1 transmit_turn_on_o);
  COV_IRQ: cover property (!int_n_o ##[1:200] int_n_o);
  COV_SATURATE: cover property (err_full);
  COV_DRV_FAULT: cover property (dmo_expire);
endmodule : liu_ctrl_regs
`default_nettype wire

// ---- hw/liu_pkg.sv ----
// constants shared by the line interface control and interrupt register logic
// Overview of operation
// - tx on bit 0 drives line output pair
// - rx on bit 4 turns receiver on
// - enable bit D0 gates driver fault interrupt
// - enable bit D1 gates signal loss interrupt
// - enable bit D2 gates lock loss interrupt
// - enable bit D3 gates fifo limit interrupt
// - fifo limit interrupt off while attenuator disabled
// - enable bit D4 gates pattern error interrupt
// - driver fault change sets flag, read clears
// - signal loss change sets flag, read clears
// - lock loss change sets flag, read clears
// - fifo limit change sets flag, read clears
// - pattern error sets flag, read clears
// - counter saturates at FFFF, sets flag
// - read-only part and revision identifier bytes
// - interrupt output is active low
// - driver fault after 128 pulseless bit periods
package liu_pkg;
  // register offsets on the serial host port
  localparam logic [5:0] ADDR_LINE_CTRL = 6'h00;
  localparam logic [5:0] ADDR_IRQ_EN = 6'h01;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h02;
  localparam logic [5:0] ADDR_CNT_HIGH = 6'h30;
  localparam logic [5:0] ADDR_CNT_LOW = 6'h31;
  localparam logic [5:0] ADDR_HOLD = 6'h38;
  localparam logic [5:0] ADDR_PART = 6'h3E;
  localparam logic [5:0] ADDR_REV = 6'h3F;
  // field positions
  localparam int TX_ON_BIT = 0;
  localparam int RX_ON_BIT = 4;
  localparam int DRV_BIT = 0;
  localparam int LOS_BIT = 1;
  localparam int LOL_BIT = 2;
  localparam int FL_BIT = 3;
  localparam int PAT_BIT = 4;
  localparam int SAT_BIT = 5;
  // reset values
  localparam logic [1:0] LINE_CTRL_RST = 2'h0;
  localparam logic [5:0] IRQ_EN_RST = 6'h00;
  localparam logic [5:0] IRQ_STATUS_RST = 6'h00;
  // counts
  localparam logic [7:0] DMO_BIT_PERIODS = 8'h80;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [15:0] ERR_CNT_MAX = 16'hFFFF;
  // serial port states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_RLOAD = 7'h04,
    ST_RDATA = 7'h08,
    ST_WDATA = 7'h10,
    ST_WCOMMIT = 7'h20,
    ST_DONE = 7'h40
  } liu_state_e;
endpackage : liu_pkg

// ---- hw/liu_err_counter.sv ----
// saturating pattern error counter
`timescale 1ns/100ps
`default_nettype none
module liu_err_counter import liu_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic err_i,
  output logic [15:0] count_o,
  output logic full_o
);
  logic at_max;
  logic hit_max;

  // saturation detect
  assign at_max = (count_o == ERR_CNT_MAX);
  assign hit_max = err_i && (count_o == ERR_CNT_MAX - 16'h0001);

  // count errors and hold at the top value rather than wrap
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= 16'h0000;
      full_o <= 1'b0;
    end else begin
      if (err_i && !at_max) begin
        count_o <= count_o + 16'h0001;
      end
      full_o <= hit_max; // one pulse on reaching the top
    end
  end

  AST_CNT_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
    at_max |=> at_max)
    else $error("error counter left saturation");
endmodule : liu_err_counter
`default_nettype wire

// ---- testbench/liu_host_model.sv ----
// serial host master model that runs whole frames on the control port
`timescale 1ns/100ps
`default_nettype none
module liu_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  localparam int HALF = 5; // clk cycles per serial clock phase, above the minimum of 3
  // serial clock stands low and select high between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // one frame lsb first: r/w, six address bits, spare, eight data bits
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] wd,
      output logic [7:0] rdat);
    logic [15:0] frame;
    frame = {wd, 1'b0, a, rd};
    rdat = 8'h00;
    @(posedge clk_i);
    #1 cs_n_o = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sclk_o = 1'b0;
      sdi_o = frame[i];
      repeat (HALF) @(posedge clk_i);
      #1;
      if (i >= 8) rdat[i-8] = sdo_i; // data settled since the falling edge
      sclk_o = 1'b1;
      repeat (HALF) @(posedge clk_i);
      #1;
    end
    // let the write commit before the select rises, then idle the lines
    repeat (6) @(posedge clk_i);
    #1 cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = ~sdi_o; // released data line does not keep its last value
    repeat (4) @(posedge clk_i);
    #1; // hand back off the clock edge so the caller never races the design
  endtask : xfer
endmodule : liu_host_model
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the control and interrupt register block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import liu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n, sclk, sdi, sdo, int_n, mon, tick, los, lol, fl, ja_en, perr;
  logic tx_on, rx_on, fault, sdo_oe;
  logic oe_seen = 1'b0;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  liu_ctrl_regs #(.PART_ID(8'h3C), .REV_ID(8'h07)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .int_n_o(int_n),
    .mon_pulse_i(mon), .bit_tick_i(tick), .receive_signal_loss_i(los),
    .receive_lock_loss_i(lol), .fifo_near_limit_i(fl), .ja_enabled_i(ja_en),
    .pattern_err_i(perr), .transmit_turn_on_o(tx_on), .receive_turn_on_o(rx_on),
    .driver_monitor_fault_o(fault));
  liu_host_model i_host (.clk_i(clk_i), .sdo_i(sdo), .cs_n_o(cs_n), .sclk_o(sclk),
    .sdi_o(sdi));
  // clock and hang guard
  always #10 clk_i = ~clk_i;
  // note that the device drove its data line during a read
  always @(posedge clk_i) begin
    if (sdo_oe === 1'b1) oe_seen <= 1'b1;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_host.xfer(1'b0, a, d, x);
  endtask : wr
  task automatic rd(input string n, input logic [5:0] a, input logic [7:0] e);
    logic [7:0] x;
    i_host.xfer(1'b1, a, 8'h00, x);
    chk(n, e, x);
  endtask : rd
  task automatic setc(input int k, input logic v);
    if (k == 1) los = v;
    else if (k == 2) lol = v;
    else fl = v;
    cyc(4);
  endtask : setc
  task automatic ticks(input int n);
    repeat (n) begin
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(1);
    end
    cyc(4);
  endtask : ticks
  initial begin
    {mon, tick, los, lol, fl, perr} = 6'h00;
    ja_en = 1'b1;
    cyc(10);
    rst_i = 1'b0;
    cyc(2);
    chk("int_n", 8'h01, {7'h00, int_n});
    chk("tx_on", 8'h00, {7'h00, tx_on});
    chk("sdo_oe", 8'h00, {7'h00, sdo_oe});
    rd("line_ctrl", ADDR_LINE_CTRL, 8'h00);
    rd("irq_en", ADDR_IRQ_EN, 8'h00);
    rd("irq_status", ADDR_IRQ_STATUS, 8'h00);
    rd("part", ADDR_PART, 8'h3C);
    chk("oe_seen", 8'h01, {7'h00, oe_seen});
    wr(ADDR_REV, 8'h5A);
    rd("rev", ADDR_REV, 8'h07);
    // line enables, each bit alone
    wr(ADDR_LINE_CTRL, 8'h11);
    chk("tx_on", 8'h01, {7'h00, tx_on});
    chk("rx_on", 8'h01, {7'h00, rx_on});
    wr(ADDR_LINE_CTRL, 8'h01);
    chk("rx_on", 8'h00, {7'h00, rx_on});
    wr(ADDR_LINE_CTRL, 8'h10);
    chk("tx_on", 8'h00, {7'h00, tx_on});
    rd("line_ctrl", ADDR_LINE_CTRL, 8'h10);
    // level conditions raise, hold and release the interrupt in both directions
    wr(ADDR_IRQ_EN, 8'h3F);
    for (int k = 1; k < 4; k++) begin
      for (int v = 1; v >= 0; v--) begin
        setc(k, v[0]);
        chk("int_n", 8'h00, {7'h00, int_n});
        rd("irq_status", ADDR_IRQ_STATUS, 8'h01 << k);
        cyc(3);
        chk("int_n", 8'h01, {7'h00, int_n});
      end
    end
    // masked sources still flag but stay quiet
    wr(ADDR_IRQ_EN, 8'h00);
    for (int k = 1; k < 4; k++) setc(k, 1'b1);
    chk("int_n", 8'h01, {7'h00, int_n});
    rd("irq_status", ADDR_IRQ_STATUS, 8'h0E);
    for (int k = 1; k < 4; k++) setc(k, 1'b0);
    rd("irq_status", ADDR_IRQ_STATUS, 8'h0E);
    // fifo limit with the attenuator off
    ja_en = 1'b0;
    wr(ADDR_IRQ_EN, 8'h08);
    setc(3, 1'b1);
    chk("int_n", 8'h01, {7'h00, int_n});
    rd("irq_status", ADDR_IRQ_STATUS, 8'h08);
    setc(3, 1'b0);
    ja_en = 1'b1;
    cyc(2);
    chk("int_n", 8'h00, {7'h00, int_n});
    rd("irq_status", ADDR_IRQ_STATUS, 8'h08);
    // single pattern error, count bytes and frozen low byte
    wr(ADDR_IRQ_EN, 8'h10);
    perr = 1'b1;
    cyc(1);
    perr = 1'b0;
    cyc(3);
    chk("int_n", 8'h00, {7'h00, int_n});
    rd("irq_status", ADDR_IRQ_STATUS, 8'h10);
    rd("cnt_high", ADDR_CNT_HIGH, 8'h00);
    rd("hold", ADDR_HOLD, 8'h01);
    // driver monitor: one tick short, then the 128th
    wr(ADDR_IRQ_EN, 8'h01);
    mon = 1'b1;
    cyc(3);
    mon = 1'b0;
    cyc(4);
    ticks(127);
    chk("fault", 8'h00, {7'h00, fault});
    chk("int_n", 8'h01, {7'h00, int_n});
    ticks(1);
    chk("fault", 8'h01, {7'h00, fault});
    chk("int_n", 8'h00, {7'h00, int_n});
    rd("irq_status", ADDR_IRQ_STATUS, 8'h01);
    mon = 1'b1;
    cyc(3);
    mon = 1'b0;
    cyc(4);
    chk("fault", 8'h00, {7'h00, fault});
    rd("irq_status", ADDR_IRQ_STATUS, 8'h01);
    // run the counter past saturation
    wr(ADDR_IRQ_EN, 8'h20);
    perr = 1'b1;
    cyc(65540);
    perr = 1'b0;
    cyc(3);
    chk("int_n", 8'h00, {7'h00, int_n});
    rd("irq_status", ADDR_IRQ_STATUS, 8'h30);
    rd("cnt_high", ADDR_CNT_HIGH, 8'hFF);
    rd("cnt_low", ADDR_CNT_LOW, 8'hFF);
    final_report();
  end
endmodule : tb
`default_nettype wire
